// [design/clock_tree_pll_distribution.v]
// Clock distribution and PLL clock path, APB controlled.
// Clocks are one-cycle tick enables in the clk_in domain; the
// source ticks arrive synchronous to clk_in.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "clock_tree_map.vh"

module clock_tree_pll_distribution #(
   parameter       IRQ_COUNT  = 4,
   parameter [7:0] LOCK_TICKS = `PLL_LOCK_TICKS
) (
   // Clock, reset, enable
   input  wire                 clk_in,
   input  wire                 rstn_in,
   input  wire                 ce_in,
   // APB slave
   input  wire                 psel_in,
   input  wire                 penable_in,
   input  wire                 pwrite_in,
   input  wire [11:0]          paddr_in,
   input  wire [31:0]          pwdata_in,
   input  wire [3:0]           pstrb_in,
   output reg  [31:0]          prdata_out,
   output wire                 pready_out,
   output reg                  pslverr_out,
   // Clock sources as ticks
   input  wire                 system_clock_tick_in,
   input  wire                 rc_osc_tick_in,
   // Power management
   input  wire                 sleep_enable_in,
   input  wire [1:0]           sleep_mode_in,
   // Asynchronous interrupt inputs
   input  wire [IRQ_COUNT-1:0] async_irq_in,
   input  wire [IRQ_COUNT-1:0] async_irq_enable_in,
   output wire                 async_wake_out,
   // Domain clocks
   output reg                  core_domain_clock_out,
   output reg                  program_memory_clock_out,
   output reg                  peripheral_domain_clock_out,
   output reg                  converter_domain_clock_out,
   output reg                  two_wire_serial_interface_clock_out,
   // PLL path clocks and lock
   output reg                  pll_reference_prescaled_clock_out,
   output reg                  pll_output_clock_out,
   output reg                  usb_domain_clock_out,
   output reg                  fast_timer_clock_out,
   output reg                  pll_lock_out
);

   // ==========================================================
   // APB register file
   // ==========================================================
   reg  [7:0] pll_ctrl;
   reg  [3:0] postcaler;
   reg  [3:0] domain_stop;
   wire       bus_write = psel_in & penable_in & pwrite_in;
   wire       bus_setup = psel_in & ~penable_in;
   wire [7:0] status_byte;

   assign pready_out = 1'b1;

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pll_ctrl    <= `PLL_CTRL_RESET;
         postcaler   <= `POST_RESET;
         domain_stop <= `STOP_RESET;
      end else if (ce_in && bus_write && pstrb_in[0]) begin
         if (paddr_in == `ADDR_PLL_CTRL) begin
            pll_ctrl <= pwdata_in[7:0];
         end else if (paddr_in == `ADDR_POSTCALER) begin
            postcaler <= pwdata_in[3:0];
         end else if (paddr_in == `ADDR_DOMAIN_STOP) begin
            domain_stop <= pwdata_in[3:0];
         end
      end
   end

   // Read data and error are prepared in the setup cycle
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (ce_in && bus_setup) begin
         pslverr_out <= 1'b0;
         if (paddr_in == `ADDR_PLL_CTRL) begin
            prdata_out <= {24'h00_0000, pll_ctrl};
         end else if (paddr_in == `ADDR_POSTCALER) begin
            prdata_out <= {28'h000_0000, postcaler};
         end else if (paddr_in == `ADDR_DOMAIN_STOP) begin
            prdata_out <= {28'h000_0000, domain_stop};
         end else if (paddr_in == `ADDR_CLOCK_STATUS) begin
            prdata_out <= {24'h00_0000, status_byte};
         end else begin
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b1;
         end
      end
   end

   wire       pll_enable = pll_ctrl[`PLL_EN_BIT];
   wire       ref_select = pll_ctrl[`PLL_REF_SEL_BIT];
   wire       pre_div2   = pll_ctrl[`PLL_PRE_DIV2_BIT];
   wire [3:0] freq_sel   = pll_ctrl[`PLL_FREQ_MSB:`PLL_FREQ_LSB];
   wire [1:0] usb_ratio  = postcaler[`POST_USB_MSB:`POST_USB_LSB];
   wire [1:0] tmr_ratio  = postcaler[`POST_TMR_MSB:`POST_TMR_LSB];

   // ==========================================================
   // Prescaler and PLL input multiplexer
   // ==========================================================
   reg  pre_phase;
   reg  ref_active;
   wire pre_tick = system_clock_tick_in &
                   (~pre_div2 | pre_phase);
   // Switch only when neither source ticks, so no pulse merges
   wire ref_quiet = ~pre_tick & ~rc_osc_tick_in;
   wire ref_tick  = ref_active ? rc_osc_tick_in : pre_tick;

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pre_phase  <= 1'b0;
         ref_active <= 1'b0;
         pll_reference_prescaled_clock_out <= 1'b0;
      end else if (ce_in) begin
         if (!pre_div2) begin
            pre_phase <= 1'b0;
         end else if (system_clock_tick_in) begin
            pre_phase <= ~pre_phase;
         end
         if (ref_quiet) begin
            ref_active <= ref_select;
         end
         pll_reference_prescaled_clock_out <= pre_tick;
      end
   end

   // ==========================================================
   // PLL model: lock on reference ticks, then run
   // ==========================================================
   reg  [7:0] lock_cnt;
   reg  [3:0] freq_held;
   reg        ref_held;
   wire [3:0] freq_clip = (freq_sel > `PLL_MAX_SEL) ?
                          `PLL_MAX_SEL : freq_sel;
   wire [7:0] pll_mhz   = `PLL_BASE_MHZ +
                          {1'b0, freq_clip, 3'b000};
   wire       relock    = ~pll_enable | (freq_clip != freq_held) |
                          (ref_active != ref_held);
   wire       pll_tick;

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lock_cnt     <= 8'h00;
         freq_held    <= 4'h0;
         ref_held     <= 1'b0;
         pll_lock_out <= 1'b0;
      end else if (ce_in) begin
         freq_held <= freq_clip;
         ref_held  <= ref_active;
         if (relock) begin
            lock_cnt     <= 8'h00;
            pll_lock_out <= 1'b0;
         end else if (ref_tick && !pll_lock_out) begin
            if (lock_cnt == LOCK_TICKS - 8'h01) begin
               pll_lock_out <= 1'b1;
            end else begin
               lock_cnt <= lock_cnt + 8'h01;
            end
         end
      end
   end

   tick_rate_generator #(
      .MODULUS (`CLK_RATE_MHZ)
   ) u_pll (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .run_in   (pll_lock_out & ~relock),
      .inc_in   (pll_mhz),
      .tick_out (pll_tick)
   );

   // ==========================================================
   // Postcaler: USB and fast timer clocks
   // ==========================================================
   wire usb_tick;
   wire tmr_tick;

   tick_postcaler u_post_usb (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .ratio_in (usb_ratio),
      .tick_in  (pll_tick),
      .tick_out (usb_tick)
   );

   tick_postcaler u_post_tmr (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .ce_in    (ce_in),
      .ratio_in (tmr_ratio),
      .tick_in  (pll_tick),
      .tick_out (tmr_tick)
   );

   // USB sees 48 MHz from 48/1 or 96/2
   wire usb_rate_ok =
      ((pll_mhz == `USB_TARGET_MHZ) && (usb_ratio == `RATIO_DIV1)) ||
      ((pll_mhz == {`USB_TARGET_MHZ, 1'b0}) &&
       (usb_ratio >= `RATIO_DIV2));

   // ==========================================================
   // Sleep mode gating of the domains
   // ==========================================================
   reg core_run;
   reg periph_run;
   reg conv_run;
   reg usb_run;
   reg tmr_run;
   reg next_core_run;
   reg next_periph_run;
   reg next_conv_run;
   reg next_pll_run;

   always @* begin
      next_core_run   = 1'b1;
      next_periph_run = 1'b1;
      next_conv_run   = 1'b1;
      next_pll_run    = 1'b1;
      if (sleep_enable_in) begin
         next_core_run = 1'b0;
         case (sleep_mode_in)
            `SLEEP_IDLE: begin
               next_core_run = 1'b0;
            end
            `SLEEP_NOISE_RED: begin
               next_periph_run = 1'b0;
            end
            default: begin
               next_periph_run = 1'b0;
               next_conv_run   = 1'b0;
               next_pll_run    = 1'b0;
            end
         endcase
      end
   end

   // Gates are flops and the clocks are single-cycle ticks,
   // so a start or stop never cuts a pulse short
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         core_run   <= 1'b1;
         periph_run <= 1'b1;
         conv_run   <= 1'b1;
         usb_run    <= 1'b0;
         tmr_run    <= 1'b0;
      end else if (ce_in) begin
         core_run   <= next_core_run;
         periph_run <= next_periph_run &
                       ~domain_stop[`STOP_PERIPH_BIT];
         conv_run   <= next_conv_run &
                       ~domain_stop[`STOP_CONV_BIT];
         usb_run    <= next_pll_run & ~domain_stop[`STOP_USB_BIT];
         tmr_run    <= next_pll_run & ~domain_stop[`STOP_TMR_BIT];
      end
   end

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         core_domain_clock_out               <= 1'b0;
         program_memory_clock_out            <= 1'b0;
         peripheral_domain_clock_out         <= 1'b0;
         converter_domain_clock_out          <= 1'b0;
         two_wire_serial_interface_clock_out <= 1'b0;
         pll_output_clock_out                <= 1'b0;
         usb_domain_clock_out                <= 1'b0;
         fast_timer_clock_out                <= 1'b0;
      end else if (ce_in) begin
         core_domain_clock_out <= system_clock_tick_in &
                                  core_run;
         program_memory_clock_out <= system_clock_tick_in &
                                     core_run;
         peripheral_domain_clock_out <= system_clock_tick_in &
                                        periph_run;
         converter_domain_clock_out <= system_clock_tick_in &
                                       conv_run;
         two_wire_serial_interface_clock_out <=
            system_clock_tick_in;
         pll_output_clock_out <= pll_tick;
         usb_domain_clock_out <= usb_tick & usb_run;
         fast_timer_clock_out <= tmr_tick & tmr_run;
      end
   end

   // ==========================================================
   // Asynchronous interrupt wake path, free of any gate
   // ==========================================================
   assign async_wake_out =
      |(async_irq_in & async_irq_enable_in);

   // ==========================================================
   // Status
   // ==========================================================
   assign status_byte = {usb_rate_ok, tmr_run, usb_run, conv_run,
                         periph_run, core_run, ref_active,
                         pll_lock_out};

endmodule // clock_tree_pll_distribution
`default_nettype wire

// [design/clock_tree_map.vh]
// Address map, field positions, reset values and timing counts
// of the clock tree; included by the clock tree modules only.
`ifndef CLOCK_TREE_MAP_VH
`define CLOCK_TREE_MAP_VH

// Register byte addresses (APB, one aligned word each)
`define ADDR_PLL_CTRL      12'h000
`define ADDR_POSTCALER     12'h004
`define ADDR_DOMAIN_STOP   12'h008
`define ADDR_CLOCK_STATUS  12'h00c

// PLL control fields
`define PLL_EN_BIT         0
`define PLL_REF_SEL_BIT    1
`define PLL_PRE_DIV2_BIT   2
`define PLL_FREQ_LSB       4
`define PLL_FREQ_MSB       7
`define PLL_CTRL_RESET     8'h00

// Postcaler fields and ratio codes
`define POST_USB_LSB       0
`define POST_USB_MSB       1
`define POST_TMR_LSB       2
`define POST_TMR_MSB       3
`define POST_RESET         4'h0
`define RATIO_DIV1         2'h0
`define RATIO_DIV1P5       2'h1
`define RATIO_DIV2         2'h2

// Software domain stop fields
`define STOP_PERIPH_BIT    0
`define STOP_CONV_BIT      1
`define STOP_USB_BIT       2
`define STOP_TMR_BIT       3
`define STOP_RESET         4'h0

// Sleep mode codes from power management
`define SLEEP_IDLE         2'h0
`define SLEEP_NOISE_RED    2'h1
`define SLEEP_POWER_DOWN   2'h2
`define SLEEP_POWER_SAVE   2'h3

// PLL frequencies and steps, the clk_in rate in MHz and the PLL lock count
`define PLL_BASE_MHZ       8'd32
`define PLL_STEP_SHIFT     3
`define PLL_MAX_SEL        4'h8
`define USB_TARGET_MHZ     8'd48
`define CLK_RATE_MHZ       9'd250
`define PLL_LOCK_TICKS     8'd64

`endif

// [design/tick_rate_generator.v]
// Fractional rate generator: one tick per clk when the accumulated
// rate crosses the clock rate. Assumes inc is below the modulus.
`timescale 1ns/10ps
`default_nettype none
`include "clock_tree_map.vh"

module tick_rate_generator #(
   parameter [8:0] MODULUS = `CLK_RATE_MHZ
) (
   // Clock, reset, enable
   input  wire       clk_in,
   input  wire       rstn_in,
   input  wire       ce_in,
   // Control
   input  wire       run_in,
   input  wire [7:0] inc_in,
   // Output tick
   output reg        tick_out
);

   reg  [7:0] acc;
   wire [8:0] sum = {1'b0, acc} + {1'b0, inc_in};

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc      <= 8'h00;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         if (!run_in) begin
            acc      <= 8'h00;
            tick_out <= 1'b0;
         end else if (sum >= MODULUS) begin
            acc      <= sum[7:0] - MODULUS[7:0];
            tick_out <= 1'b1;
         end else begin
            acc      <= sum[7:0];
            tick_out <= 1'b0;
         end
      end
   end

endmodule // tick_rate_generator
`default_nettype wire

// [design/tick_postcaler.v]
// Postcaler on a tick stream: divide by 1, 1.5 or 2.
// A new ratio is taken only at a period boundary.
`timescale 1ns/10ps
`default_nettype none
`include "clock_tree_map.vh"

module tick_postcaler (
   // Clock, reset, enable
   input  wire       clk_in,
   input  wire       rstn_in,
   input  wire       ce_in,
   // Ratio and ticks
   input  wire [1:0] ratio_in,
   input  wire       tick_in,
   output wire       tick_out
);

   reg  [1:0] ratio;
   reg  [1:0] cnt;
   wire [1:0] last = (ratio == `RATIO_DIV1)   ? 2'h0 :
                     (ratio == `RATIO_DIV1P5) ? 2'h2 : 2'h1;
   wire       pass = (ratio == `RATIO_DIV1)   ? 1'b1 :
                     (ratio == `RATIO_DIV1P5) ? (cnt != 2'h2) :
                     (cnt == 2'h1);

   assign tick_out = tick_in & pass;

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ratio <= `RATIO_DIV1;
         cnt   <= 2'h0;
      end else if (ce_in && tick_in) begin
         if (cnt == last) begin
            cnt   <= 2'h0;
            ratio <= ratio_in;
         end else begin
            cnt <= cnt + 2'h1;
         end
      end
   end

endmodule // tick_postcaler
`default_nettype wire

// [verif/clock_tree_monitor.sv]
// Checker of the clock tree ports: domain gating, sources, PLL lock.
// Assumes a bind into the top module with ce_in held high.
`timescale 1ns/10ps
`default_nettype none
module clock_tree_monitor #(
   parameter       IRQ_COUNT  = 4,
   parameter [7:0] LOCK_TICKS = 8'h40
) (
   // Clock, reset and controls
   input wire logic                 clk_in,
   input wire logic                 rstn_in,
   input wire logic                 system_clock_tick_in,
   input wire logic                 sleep_enable_in,
   input wire logic [1:0]           sleep_mode_in,
   input wire logic [IRQ_COUNT-1:0] async_irq_in,
   input wire logic [IRQ_COUNT-1:0] async_irq_enable_in,
   // Watched outputs
   input wire logic                 async_wake_out,
   input wire logic                 core_domain_clock_out,
   input wire logic                 program_memory_clock_out,
   input wire logic                 peripheral_domain_clock_out,
   input wire logic                 converter_domain_clock_out,
   input wire logic                 two_wire_serial_interface_clock_out,
   input wire logic                 pll_output_clock_out,
   input wire logic                 usb_domain_clock_out,
   input wire logic                 fast_timer_clock_out,
   input wire logic                 pll_lock_out
);
   // ======================================
   // Helpers: cycles since reset, cycles without lock
   logic [1:0] up;
   logic [7:0] low_run;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         up      <= 2'h0;
         low_run <= 8'h00;
      end else begin
         if (!up[1])
            up <= up + 2'h1;
         if (pll_lock_out)
            low_run <= 8'h00;
         else if (low_run != 8'hff)
            low_run <= low_run + 8'h01;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // ======================================
   // Assertions
   AST_CORE_STOPS_ASLEEP: assert property (
      up[1] && $past(sleep_enable_in, 2) |-> !core_domain_clock_out)
      else $error("core clock ran in sleep");
   AST_PERIPH_FROM_SOURCE: assert property (
      peripheral_domain_clock_out |-> $past(system_clock_tick_in))
      else $error("peripheral tick without source tick");
   AST_WAKE_ALWAYS: assert property (
      async_wake_out == |(async_irq_in & async_irq_enable_in))
      else $error("wake output wrong");
   AST_SERIAL_NEVER_STOPS: assert property (
      up[1] |-> two_wire_serial_interface_clock_out ==
      $past(system_clock_tick_in))
      else $error("serial clock not following source");
   AST_FLASH_WITH_CORE: assert property (
      program_memory_clock_out == core_domain_clock_out)
      else $error("flash clock differs from core clock");
   AST_UNUSED_STOPPED: assert property (
      up[1] && $past(sleep_enable_in && sleep_mode_in != 2'h0, 2)
      |-> !peripheral_domain_clock_out)
      else $error("peripheral clock ran in deep sleep");
   AST_DEEP_SLEEP_STOPS: assert property (
      up[1] && $past(sleep_enable_in && sleep_mode_in[1], 2) |->
      !(converter_domain_clock_out || usb_domain_clock_out ||
      fast_timer_clock_out))
      else $error("clock ran in power down");
   AST_NO_TICK_UNLOCKED: assert property (
      !pll_lock_out [*3] |-> !pll_output_clock_out)
      else $error("PLL tick without lock");
   AST_LOCK_WAIT: assert property (
      $rose(pll_lock_out) |-> low_run >= LOCK_TICKS - 8'h01)
      else $error("PLL locked too early");
   COV_NOISE_RED: cover property (sleep_enable_in &&
      sleep_mode_in == 2'h1 && converter_domain_clock_out);
   COV_LOCK: cover property ($rose(pll_lock_out));
   COV_USB: cover property (usb_domain_clock_out);
endmodule // clock_tree_monitor

bind clock_tree_pll_distribution clock_tree_monitor #(
   .IRQ_COUNT (IRQ_COUNT), .LOCK_TICKS (LOCK_TICKS)
) i_monitor (
   .clk_in (clk_in), .rstn_in (rstn_in),
   .system_clock_tick_in (system_clock_tick_in),
   .sleep_enable_in (sleep_enable_in), .sleep_mode_in (sleep_mode_in),
   .async_irq_in (async_irq_in),
   .async_irq_enable_in (async_irq_enable_in),
   .async_wake_out (async_wake_out),
   .core_domain_clock_out (core_domain_clock_out),
   .program_memory_clock_out (program_memory_clock_out),
   .peripheral_domain_clock_out (peripheral_domain_clock_out),
   .converter_domain_clock_out (converter_domain_clock_out),
   .two_wire_serial_interface_clock_out
      (two_wire_serial_interface_clock_out),
   .pll_output_clock_out (pll_output_clock_out),
   .usb_domain_clock_out (usb_domain_clock_out),
   .fast_timer_clock_out (fast_timer_clock_out),
   .pll_lock_out (pll_lock_out)
);
`default_nettype wire

// [verif/clock_source_model.sv]
// Source model: system clock and internal oscillator as tick pulses.
// Assumes clk_in at 250 MHz; the system rate is given in MHz.
`timescale 1ns/10ps
`default_nettype none
module clock_source_model (
   // Clock and rate
   input  wire logic       clk_in,
   input  wire logic [7:0] sys_mhz_in,
   // Source ticks
   output var  logic       system_tick_out,
   output var  logic       rc_tick_out
);
   // ======================================
   // Rate accumulators, modulus 250
   logic [8:0] sys_acc = 9'h000;
   logic [8:0] rc_acc  = 9'h000;
   initial begin
      system_tick_out = 1'b0;
      rc_tick_out     = 1'b0;
   end
   always @(posedge clk_in) begin
      system_tick_out <= sys_acc + sys_mhz_in >= 9'hfa;
      sys_acc <= (sys_acc + sys_mhz_in) % 9'hfa;
      rc_tick_out <= rc_acc + 9'h008 >= 9'hfa;
      rc_acc <= (rc_acc + 9'h008) % 9'hfa;
   end
endmodule // clock_source_model
`default_nettype wire

// [verif/clock_tree_pll_distribution_bench.sv]
// Self-checking bench of the clock tree: APB, sleep gating, PLL path.
// Assumes the design, the monitor and the source model are compiled.
`timescale 1ns/10ps
`default_nettype none
module clock_tree_pll_distribution_bench;
   // ======================================
   // Signals
   logic        clk, rstn, psel, penable, pwrite, sleep_en, sys_d, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic [3:0]  pstrb, irq, irq_en, r, m;
   logic [1:0]  sleep_mode;
   logic [7:0]  sys_mhz;
   wire logic   pready, pslverr, wake, sys_tick, rc_tick;
   wire logic [8:0] ticks;
   int          cnt[9];
   bit          counting;
   int          failures, checked, sel, n, p;
   assign ticks[0] = sys_d;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   clock_source_model i_src (.clk_in (clk), .sys_mhz_in (sys_mhz),
      .system_tick_out (sys_tick), .rc_tick_out (rc_tick));
   clock_tree_pll_distribution #(.LOCK_TICKS (8'h04)) i_dut (
      .clk_in (clk), .rstn_in (rstn), .ce_in (1'b1),
      .psel_in (psel), .penable_in (penable), .pwrite_in (pwrite),
      .paddr_in (paddr), .pwdata_in (pwdata), .pstrb_in (pstrb),
      .prdata_out (prdata), .pready_out (pready), .pslverr_out (pslverr),
      .system_clock_tick_in (sys_tick), .rc_osc_tick_in (rc_tick),
      .sleep_enable_in (sleep_en), .sleep_mode_in (sleep_mode),
      .async_irq_in (irq), .async_irq_enable_in (irq_en),
      .async_wake_out (wake), .core_domain_clock_out (ticks[1]),
      .program_memory_clock_out (), .peripheral_domain_clock_out (ticks[2]),
      .converter_domain_clock_out (ticks[3]),
      .two_wire_serial_interface_clock_out (ticks[4]),
      .pll_reference_prescaled_clock_out (ticks[5]),
      .pll_output_clock_out (ticks[6]), .usb_domain_clock_out (ticks[7]),
      .fast_timer_clock_out (ticks[8]), .pll_lock_out ());
   // ======================================
   // Tick counting over a window
   always @(posedge clk) begin
      sys_d <= sys_tick;
      if (counting)
         for (int i = 0; i < 9; i++) cnt[i] += ticks[i];
   end
   task automatic window(input int len);
      for (int i = 0; i < 9; i++) cnt[i] = 0;
      counting <= 1'b1;
      repeat (len) @(posedge clk);
      counting <= 1'b0;
   endtask
   // ======================================
   // Expectations, compare, bus
   function automatic logic [3:0] run_mask(input int k);
      case (k)
         0: return 4'b1110;
         1: return 4'b1100;
         2, 3: return 4'b1000;
         4: return 4'b1111;
         default: return 4'b1001;
      endcase
   endfunction
   function automatic int post(input int c, input logic [1:0] q);
      return q == 2'h0 ? c : q == 2'h1 ? c * 2 / 3 : c / 2;
   endfunction
   function automatic logic [31:0] near(input int a, input int b);
      return 32'(a - b <= 2 && b - a <= 2);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Whole run is near 17k cycles; this cuts a hang at 100k
   initial begin
      #400000;
      failures++;
      tally_and_finish();
   end
   // ======================================
   // Main sequence
   initial begin
      {rstn, psel, penable, pwrite, sleep_en, counting} = 6'h00;
      {paddr, pwdata, irq, irq_en, sleep_mode} = 54'h0;
      pstrb = 4'hf;
      sys_mhz = 8'h10;
      void'($urandom(32'hb96762df));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 15; i++) begin
         d = i < 3 ? 32'h0 : $urandom;
         paddr <= 12'(4 * (i % 3));
         if (i >= 3) apb(1'b1, 12'(4 * (i % 3)), d);
         apb(1'b0, 12'(4 * (i % 3)), 32'h0);
         check(rd, d & (i % 3 == 0 ? 32'hff : 32'hf));
      end
      apb(1'b1, 12'h00c, 32'hffffffff);
      check(32'(err), 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check({err, rd[30:0]}, 32'h80000000);
      apb(1'b1, 12'h008, 32'h0);
      pstrb <= 4'he;
      apb(1'b1, 12'h008, 32'hf);
      pstrb <= 4'hf;
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h0);
      for (int k = 0; k < 6; k++) begin
         sleep_en <= k < 4;
         sleep_mode <= 2'(k);
         if (k == 5) apb(1'b1, 12'h008, 32'h3);
         repeat (4) @(posedge clk);
         window(500);
         m = run_mask(k);
         for (int j = 0; j < 4; j++)
            check(cnt[j+1],m[j]?cnt[0]:0);
      end
      apb(1'b1, 12'h008, 32'h0);
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, 12'h000, 32'(4 * j));
         repeat (4) @(posedge clk);
         window(1000);
         check(near(cnt[5] * (j + 1), cnt[0]), 32'h1);
      end
      for (int i = 0; i < 10; i++) begin
         sel = i < 9 ? i : $urandom_range(15, 9);
         r = 4'($urandom);
         if (i == 2) r[1:0] = 2'h0;
         if (i == 8) r[1:0] = 2'h2;
         apb(1'b1, 12'h004, {28'h0, r});
         apb(1'b1, 12'h000, {24'h0, 4'(sel), 1'b0, ~i[0], i[0], 1'b1});
         // Let a reference switch drop the old lock before polling
         repeat (4) @(posedge clk);
         n = 0;
         do begin
            apb(1'b0, 12'h00c, 32'h0);
            n++;
         end while (rd[0] !== 1'b1 && n < 200);
         check(32'(rd[0]), 32'h1);
         check(32'(rd[7]), 32'((sel == 2 && r[1:0] == 2'h0) ||
            (sel >= 8 && r[1])));
         window(1000);
         p = (32 + 8 * (sel > 8 ? 8 : sel)) * 4;
         check(near(cnt[6], p), 32'h1);
         check(near(cnt[7], post(p, r[1:0])), 32'h1);
         check(near(cnt[8], post(p, r[3:2])), 32'h1);
      end
      sleep_en <= 1'b1;
      sleep_mode <= 2'h2;
      for (int i = 0; i < 8; i++) begin
         {irq, irq_en} <= 8'($urandom);
         @(posedge clk);
         check(32'(wake), 32'(|(irq & irq_en)));
      end
      tally_and_finish();
   end
endmodule // clock_tree_pll_distribution_bench
`default_nettype wire
